// ==== hdl/mgct_pkg.sv ====
// Shared constants and types of the multichannel gated counter timer
package mgct_pkg;
  localparam int NCH = 8;
  localparam int CW = 32;
  localparam int TW = 40;
  localparam int CH_IW = 3;
  localparam int CLK_HZ = 200_000_000;
  localparam int CLK_NS = 5;
  localparam int US_NS = 1000;
  localparam int TICK_CYC = US_NS / CLK_NS;
  localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1);
  localparam int BTN_SHORT_S = 1;
  localparam int BTN_LONG_S = 3;
  localparam int SNAP_DEPTH = 56000;
  localparam int ENT_WORDS = NCH + 1;
  localparam int SNAP_WORDS = SNAP_DEPTH * ENT_WORDS;
  localparam int SAW = 19;
  localparam logic [3:0] ENT_LAST = 4'(ENT_WORDS - 1);
  localparam logic [15:0] SNAP_FULL = 16'(SNAP_DEPTH);
  localparam int LIM_CH = 7;
  // Register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_PTMR_LO = 8'h08;
  localparam logic [7:0] A_PTMR_HI = 8'h0c;
  localparam logic [7:0] A_PCNT = 8'h10;
  localparam logic [7:0] A_DISP = 8'h14;
  localparam logic [7:0] A_SON = 8'h18;
  localparam logic [7:0] A_SOFF = 8'h1c;
  localparam logic [7:0] A_SCNT = 8'h20;
  localparam logic [7:0] A_SIDX = 8'h24;
  localparam logic [7:0] A_SDATA = 8'h28;
  localparam logic [7:0] A_TMR = 8'h2c;
  localparam logic [7:0] A_CNT = 8'h40;
  localparam logic [7:0] A_CNT_END = 8'h60;
  // Control register fields
  localparam int B_START = 0;
  localparam int B_STOP = 1;
  localparam int B_CLR = 2;
  localparam int B_MODE = 4;
  localparam int B_INV = 8;
  localparam int B_SRC = 12;
  localparam int B_SEN = 13;
  // Status register fields
  localparam int B_ST = 0;
  localparam int B_GATE = 3;
  localparam int B_FULL = 4;
  localparam int B_FW = 5;
  // Stop modes
  localparam logic [1:0] SM_NONE = 2'h0;
  localparam logic [1:0] SM_TMR = 2'h1;
  localparam logic [1:0] SM_CH7 = 2'h2;
  // Display selections
  localparam logic [1:0] DS_CNT = 2'h0;
  localparam logic [1:0] DS_TMR = 2'h1;
  localparam logic [1:0] DS_PCNT = 2'h2;
  localparam logic [1:0] DS_PTMR = 2'h3;
  // Reset values
  localparam logic [TW-1:0] PTMR_RST = 40'h00_0000_0001;
  localparam logic [CW-1:0] PCNT_RST = 32'h0000_0001;
  localparam logic [CW-1:0] SPH_RST = 32'h0000_03e8;
  localparam logic [3:0] INV_RST = 4'h0;
  localparam logic [3:0] DISP_RST = 4'h4;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_DONE = 3'b100
  } mgct_run_t;
endpackage : mgct_pkg

// ==== hdl/mgct_chan.sv ====
// One 32-bit pulse counter channel
`timescale 1ns/100ps
module mgct_chan (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic inc,
  output logic [mgct_pkg::CW-1:0] cnt
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
    end else if (clr) begin
      cnt <= '0;
    end else if (inc) begin
      cnt <= cnt + 1'b1;
    end
  end
endmodule : mgct_chan

// ==== hdl/mgct_top.sv ====
// Counter timer core with AHB-Lite registers, snapshot store and reset button
// Operation
// [RL1] Eight independent 32-bit counters plus one microsecond elapsed timer.
// [RL2] A run ends on timer preset or channel 7 preset per stop mode.
// [RL3] Timer preset in microseconds, 1 us up to one million seconds.
// [RL4] Count preset from 1 up to about 4.29 billion counts.
// [RL5] Only channel 7 can end a run by reaching its preset.
// [RL6] Rising start edge begins counting; unconnected start reads low.
// [RL7] After a limit stop in a limit mode, start is ignored.
// [RL8] Rising stop edge halts counting; unconnected stop reads low.
// [RL9] Gate low suspends counting, high resumes; unconnected gate reads high.
// [RL10] Run output is active while counting is in progress.
// [RL11] Other units may use our run output as their gate.
// [RL12] Start, stop, gate and run polarity invertible; default active high.
// [RL13] Snapshots stored on gate or internal clock edges, up to 56000 entries.
// [RL14] Each entry is one word per channel, then one timer word.
// [RL15] Front indicator lit while the counting gate is open.
// [RL16] Button under 1 s resets, over 3 s enters firmware update.
// [RL17] Two display rows each show one of four selectable values.
// [RL18] Counter increments per input pulse only while run and gate active.
//
// Added by the designer: the AHB-Lite register port and the register offsets.
`timescale 1ns/100ps
module mgct_top #(
  parameter int BTN_SHORT_CYC = mgct_pkg::BTN_SHORT_S * mgct_pkg::CLK_HZ,
  parameter int BTN_LONG_CYC = mgct_pkg::BTN_LONG_S * mgct_pkg::CLK_HZ
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [mgct_pkg::NCH-1:0] cnt_in,
  input wire logic start_in,
  input wire logic stop_in,
  input wire logic gate_in,
  input wire logic reset_btn_n,
  output logic run_out,
  output logic gate_led,
  output logic sys_rst_req,
  output logic fw_update,
  output logic [31:0] disp_top,
  output logic [31:0] disp_bot
);
  localparam int NCH = mgct_pkg::NCH;
  localparam int SW = NCH + 4;
  localparam logic [SW-1:0] SY_RST = {1'b1, {(SW - 1){1'b0}}};

  logic [SW-1:0] sy1_r, sy2_r, sy3_r;
  logic dph_r, ap_wr_r, hreadyout_r, hresp_r;
  logic [7:0] ap_addr_r;
  logic [31:0] hrdata_r, rd;
  logic [1:0] mode_r;
  logic [3:0] inv_r, disp_sel_r;
  logic src_int_r, snap_en_r;
  logic [mgct_pkg::TW-1:0] ptmr_r, timer_r;
  logic [31:0] pcnt_r, son_r, soff_r, ph_cnt_r, press_r, disp_top_r, disp_bot_r;
  logic [mgct_pkg::SAW-1:0] sidx_r, wptr_r;
  mgct_pkg::mgct_run_t st_r;
  logic [7:0] presc_r;
  logic ph_r, gate_q_r, busy_r, run_out_r, gate_led_r, rstreq_r, fw_r;
  logic [3:0] widx_r;
  logic [15:0] ents_r;
  logic [31:0] shadow_r [mgct_pkg::ENT_WORDS];
  logic [31:0] mem [mgct_pkg::SNAP_WORDS];
  logic [mgct_pkg::CW-1:0] cnt_w [NCH];
  logic [NCH-1:0] cnt_rise;
  logic acc, wen, start_rise, stop_rise, gate_lv, gate_on, active, tick;
  logic cmd_start, cmd_stop, clr, limit_hit, trig, full, btn_lv;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sy1_r <= SY_RST;
      sy2_r <= SY_RST;
      sy3_r <= SY_RST;
    end else begin
      sy1_r <= {reset_btn_n, gate_in, stop_in, start_in, cnt_in};
      sy2_r <= sy1_r;
      sy3_r <= sy2_r;
    end
  end

  assign start_rise = (sy2_r[NCH] ^ inv_r[0]) & ~(sy3_r[NCH] ^ inv_r[0]); // RL6 RL12
  assign stop_rise = (sy2_r[NCH+1] ^ inv_r[1]) & ~(sy3_r[NCH+1] ^ inv_r[1]); // RL8 RL12
  assign gate_lv = sy2_r[NCH+2] ^ inv_r[2]; // RL12
  assign btn_lv = ~sy2_r[NCH+3];
  assign cnt_rise = sy2_r[NCH-1:0] & ~sy3_r[NCH-1:0];
  // Internal clock phase also gates counting in internal snapshot mode
  assign gate_on = gate_lv & (ph_r | ~src_int_r); // RL9
  assign active = (st_r == mgct_pkg::ST_RUN) & gate_on; // RL18

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: one wait state on every transfer
  assign acc = hsel & htrans[1] & hready;
  assign wen = dph_r & ap_wr_r;
  assign cmd_start = wen & (ap_addr_r == mgct_pkg::A_CTRL) & hwdata[mgct_pkg::B_START];
  assign cmd_stop = wen & (ap_addr_r == mgct_pkg::A_CTRL) & hwdata[mgct_pkg::B_STOP];
  assign clr = wen & (ap_addr_r == mgct_pkg::A_CTRL) & hwdata[mgct_pkg::B_CLR];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_r <= 1'b0;
      ap_wr_r <= 1'b0;
      ap_addr_r <= '0;
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
    end else if (dph_r) begin
      dph_r <= 1'b0;
      hreadyout_r <= 1'b1;
    end else if (acc) begin
      dph_r <= 1'b1;
      ap_wr_r <= hwrite;
      ap_addr_r <= haddr[7:0];
      hreadyout_r <= 1'b0;
    end
  end

  always_comb begin
    rd = '0;
    case (ap_addr_r)
      mgct_pkg::A_CTRL: begin
        rd[mgct_pkg::B_MODE+:2] = mode_r;
        rd[mgct_pkg::B_INV+:4] = inv_r;
        rd[mgct_pkg::B_SRC] = src_int_r;
        rd[mgct_pkg::B_SEN] = snap_en_r;
      end
      mgct_pkg::A_STAT: begin
        rd[mgct_pkg::B_ST+:3] = st_r;
        rd[mgct_pkg::B_GATE] = gate_on;
        rd[mgct_pkg::B_FULL] = full;
        rd[mgct_pkg::B_FW] = fw_r;
      end
      mgct_pkg::A_PTMR_LO: rd = ptmr_r[31:0];
      mgct_pkg::A_PTMR_HI: rd[mgct_pkg::TW-33:0] = ptmr_r[mgct_pkg::TW-1:32];
      mgct_pkg::A_PCNT: rd = pcnt_r;
      mgct_pkg::A_DISP: rd[3:0] = disp_sel_r;
      mgct_pkg::A_SON: rd = son_r;
      mgct_pkg::A_SOFF: rd = soff_r;
      mgct_pkg::A_SCNT: rd[15:0] = ents_r;
      mgct_pkg::A_SIDX: rd[mgct_pkg::SAW-1:0] = sidx_r;
      mgct_pkg::A_TMR: rd = timer_r[31:0];
      default: begin
        if (ap_addr_r >= mgct_pkg::A_CNT && ap_addr_r < mgct_pkg::A_CNT_END) begin
          rd = cnt_w[ap_addr_r[mgct_pkg::CH_IW+1:2]];
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= '0;
    end else if (dph_r && !ap_wr_r) begin
      hrdata_r <= (ap_addr_r == mgct_pkg::A_SDATA) ? mem[sidx_r] : rd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_r <= mgct_pkg::SM_NONE;
      inv_r <= mgct_pkg::INV_RST; // RL12
      src_int_r <= 1'b0;
      snap_en_r <= 1'b0;
      ptmr_r <= mgct_pkg::PTMR_RST;
      pcnt_r <= mgct_pkg::PCNT_RST;
      disp_sel_r <= mgct_pkg::DISP_RST;
      son_r <= mgct_pkg::SPH_RST;
      soff_r <= mgct_pkg::SPH_RST;
      sidx_r <= '0;
    end else if (wen) begin
      case (ap_addr_r)
        mgct_pkg::A_CTRL: begin
          mode_r <= hwdata[mgct_pkg::B_MODE+:2]; // RL2
          inv_r <= hwdata[mgct_pkg::B_INV+:4]; // RL12
          src_int_r <= hwdata[mgct_pkg::B_SRC];
          snap_en_r <= hwdata[mgct_pkg::B_SEN];
        end
        mgct_pkg::A_PTMR_LO: ptmr_r[31:0] <= hwdata; // RL3
        mgct_pkg::A_PTMR_HI: ptmr_r[mgct_pkg::TW-1:32] <= hwdata[mgct_pkg::TW-33:0]; // RL3
        mgct_pkg::A_PCNT: pcnt_r <= hwdata; // RL4
        mgct_pkg::A_DISP: disp_sel_r <= hwdata[3:0]; // RL17
        mgct_pkg::A_SON: son_r <= hwdata;
        mgct_pkg::A_SOFF: soff_r <= hwdata;
        mgct_pkg::A_SIDX: sidx_r <= hwdata[mgct_pkg::SAW-1:0];
        default: ;
      endcase
    end else if (dph_r && ap_addr_r == mgct_pkg::A_SDATA) begin
      sidx_r <= sidx_r + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Run control
  assign limit_hit = (mode_r == mgct_pkg::SM_TMR && timer_r >= ptmr_r) // RL2
    || (mode_r == mgct_pkg::SM_CH7 && cnt_w[mgct_pkg::LIM_CH] >= pcnt_r); // RL5

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= mgct_pkg::ST_IDLE;
    end else begin
      unique case (st_r)
        mgct_pkg::ST_IDLE: begin
          if ((start_rise || cmd_start) && !stop_rise && !cmd_stop) begin
            st_r <= mgct_pkg::ST_RUN; // RL6
          end
        end
        mgct_pkg::ST_RUN: begin
          if (stop_rise || cmd_stop) begin
            st_r <= mgct_pkg::ST_IDLE; // RL8
          end else if (limit_hit) begin
            st_r <= mgct_pkg::ST_DONE; // RL2
          end
        end
        mgct_pkg::ST_DONE: begin
          // Start stays locked out until software clears
          if (clr) begin
            st_r <= mgct_pkg::ST_IDLE; // RL7
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Microsecond timer and counters
  assign tick = (presc_r == mgct_pkg::TICK_LAST);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      presc_r <= '0;
    end else begin
      presc_r <= tick ? '0 : presc_r + 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_r <= '0;
    end else if (clr) begin
      timer_r <= '0;
    end else if (tick && active) begin
      timer_r <= timer_r + 1'b1; // RL1 RL3
    end
  end

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    mgct_chan u_chan (
      .clk(hclk),
      .rst_n(hresetn),
      .clr(clr),
      .inc(active & cnt_rise[i]), // RL18
      .cnt(cnt_w[i])
    ); // RL1
  end

  ////////////////////////////////////////////////////////////////////////////
  // Internal snapshot clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_r <= 1'b1;
      ph_cnt_r <= '0;
    end else if (st_r != mgct_pkg::ST_RUN || !src_int_r) begin
      ph_r <= 1'b1;
      ph_cnt_r <= '0;
    end else if (tick) begin
      if (ph_cnt_r + 1'b1 >= (ph_r ? son_r : soff_r)) begin
        ph_r <= ~ph_r; // RL13
        ph_cnt_r <= '0;
      end else begin
        ph_cnt_r <= ph_cnt_r + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Snapshot store
  assign full = (ents_r == mgct_pkg::SNAP_FULL);
  assign trig = snap_en_r & (st_r == mgct_pkg::ST_RUN) & (gate_on ^ gate_q_r) & ~busy_r & ~full;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gate_q_r <= 1'b0;
      busy_r <= 1'b0;
      widx_r <= '0;
      wptr_r <= '0;
      ents_r <= '0;
      for (int k = 0; k < mgct_pkg::ENT_WORDS; k++) begin
        shadow_r[k] <= '0;
      end
    end else begin
      gate_q_r <= gate_on;
      if (clr) begin
        busy_r <= 1'b0;
        widx_r <= '0;
        wptr_r <= '0;
        ents_r <= '0;
      end else if (busy_r) begin
        wptr_r <= wptr_r + 1'b1;
        if (widx_r == mgct_pkg::ENT_LAST) begin
          busy_r <= 1'b0;
          widx_r <= '0;
          ents_r <= ents_r + 1'b1; // RL13
        end else begin
          widx_r <= widx_r + 1'b1;
        end
      end else if (trig) begin
        busy_r <= 1'b1; // RL13
        for (int k = 0; k < NCH; k++) begin
          shadow_r[k] <= cnt_w[k]; // RL14
        end
        shadow_r[NCH] <= timer_r[31:0]; // RL14
      end
    end
  end

  always_ff @(posedge hclk) begin
    if (busy_r) begin
      mem[wptr_r] <= shadow_r[widx_r]; // RL14
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset button timing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      press_r <= '0;
      rstreq_r <= 1'b0;
      fw_r <= 1'b0;
    end else begin
      rstreq_r <= 1'b0;
      if (btn_lv) begin
        if (press_r < BTN_LONG_CYC) begin
          press_r <= press_r + 1'b1;
        end else begin
          fw_r <= 1'b1; // RL16
        end
      end else begin
        press_r <= '0;
        rstreq_r <= (press_r != '0) && (press_r < BTN_SHORT_CYC); // RL16
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  function automatic logic [31:0] disp_val(input logic [1:0] sel, input logic [31:0] c0,
      input logic [31:0] t, input logic [31:0] pc, input logic [31:0] pt);
    logic [31:0] v;
    unique case (sel)
      mgct_pkg::DS_CNT: v = c0;
      mgct_pkg::DS_TMR: v = t;
      mgct_pkg::DS_PCNT: v = pc;
      mgct_pkg::DS_PTMR: v = pt;
    endcase
    return v;
  endfunction : disp_val

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_out_r <= 1'b0;
      gate_led_r <= 1'b0;
      disp_top_r <= '0;
      disp_bot_r <= '0;
    end else begin
      run_out_r <= (st_r == mgct_pkg::ST_RUN) ^ inv_r[3]; // RL10 RL12
      gate_led_r <= active; // RL15
      disp_top_r <= disp_val(disp_sel_r[1:0], cnt_w[0], timer_r[31:0], pcnt_r, ptmr_r[31:0]); // RL17
      disp_bot_r <= disp_val(disp_sel_r[3:2], cnt_w[0], timer_r[31:0], pcnt_r, ptmr_r[31:0]); // RL17
    end
  end

  assign hreadyout = hreadyout_r;
  assign hrdata = hrdata_r;
  assign hresp = hresp_r;
  assign run_out = run_out_r;
  assign gate_led = gate_led_r;
  assign sys_rst_req = rstreq_r;
  assign fw_update = fw_r;
  assign disp_top = disp_top_r;
  assign disp_bot = disp_bot_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  start_run_a: assert property (st_r == mgct_pkg::ST_IDLE && start_rise && !stop_rise && !cmd_stop
      |=> st_r == mgct_pkg::ST_RUN ##1 run_out_r != inv_r[3]) // RL6
    else $error("start edge did not begin a run");
  done_lock_a: assert property (st_r == mgct_pkg::ST_DONE && !clr |=> st_r == mgct_pkg::ST_DONE) // RL7
    else $error("run restarted after limit stop");
  stop_halt_a: assert property (st_r == mgct_pkg::ST_RUN && stop_rise
      |=> st_r == mgct_pkg::ST_IDLE ##1 run_out_r == inv_r[3]) // RL8
    else $error("stop edge did not halt run");
  gate_hold_a: assert property (!gate_on && !clr |=> $stable(cnt_w[0]) && $stable(timer_r)) // RL9
    else $error("count moved while gate closed");
  timer_stop_a: assert property (st_r == mgct_pkg::ST_RUN && mode_r == mgct_pkg::SM_TMR
      && timer_r >= ptmr_r && !stop_rise && !cmd_stop |=> st_r == mgct_pkg::ST_DONE) // RL2
    else $error("timer limit did not end run");
  ch7_stop_a: assert property (st_r == mgct_pkg::ST_RUN && mode_r != mgct_pkg::SM_CH7
      && mode_r != mgct_pkg::SM_TMR |=> st_r != mgct_pkg::ST_DONE) // RL5
    else $error("run ended by count outside channel 7 mode");
  count_inc_a: assert property (active && cnt_rise[1] && !clr
      |=> cnt_w[1] == $past(cnt_w[1]) + 1'b1) // RL18
    else $error("counter missed a pulse");
  led_gate_a: assert property (active ##1 active |-> gate_led_r ##1 gate_led_r) // RL15
    else $error("indicator not lit while counting");
  entry_len_a: assert property ($rose(busy_r) |-> busy_r [*8] ##1 (busy_r && widx_r == mgct_pkg::ENT_LAST) ##1 !busy_r) // RL14
    else $error("snapshot entry length wrong");
  btn_reset_a: assert property (rstreq_r |-> !fw_r && !btn_lv) // RL16
    else $error("reset request during long press");

  run_c: cover property (st_r == mgct_pkg::ST_IDLE ##1 st_r == mgct_pkg::ST_RUN);
  done_c: cover property (st_r == mgct_pkg::ST_RUN ##1 st_r == mgct_pkg::ST_DONE);
  snap_c: cover property ($fell(busy_r));
  rstreq_c: cover property (rstreq_r);
endmodule : mgct_top

// ==== tb/mgct_pins.sv ====
// Model of the external instruments on start, stop, gate and count pins
`timescale 1ns/100ps
module mgct_pins (
  input wire logic hclk,
  output logic [mgct_pkg::NCH-1:0] cnt_out,
  output logic start_out,
  output logic stop_out,
  output logic gate_out
);
  // Unconnected levels: start and stop low, gate high
  initial begin
    cnt_out = '0;
    start_out = 1'b0;
    stop_out = 1'b0;
    gate_out = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge hclk);
  endtask : hold
  // Rising edge on start or stop, held long enough to pass the syncs
  task automatic kick(input logic stp);
    stop_out <= stp;
    start_out <= ~stp;
    hold(3);
    stop_out <= 1'b0;
    start_out <= 1'b0;
    hold(3);
  endtask : kick
  // Pulses at least two cycles high and two low
  task automatic burst(input logic [mgct_pkg::NCH-1:0] m, input int n);
    repeat (n) begin
      cnt_out <= m;
      hold(2);
      cnt_out <= '0;
      hold(2);
    end
  endtask : burst
  // Gate level change, then room for one snapshot entry
  task automatic gate(input logic g);
    gate_out <= g;
    hold(12);
  endtask : gate
endmodule : mgct_pins

// ==== tb/mgct_top_tb.sv ====
// Self-checking bench of the counter timer core
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; $display("MISMATCH %0t value differs", $time); end end
module mgct_top_tb;
  logic hclk, hresetn, hsel, hwrite, reset_btn_n;
  logic [31:0] haddr, hwdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  wire logic hreadyout, hresp, run_out, gate_led, sys_rst_req, fw_update, start_p, stop_p, gate_p;
  wire logic [31:0] hrdata, disp_top, disp_bot;
  wire logic [mgct_pkg::NCH-1:0] cnt_p;
  int failures, check_count;
  integer seed;
  int nexp [8];
  logic [7:0] rst_a [6] = '{mgct_pkg::A_CTRL, mgct_pkg::A_PTMR_LO, mgct_pkg::A_PCNT, mgct_pkg::A_DISP,
    mgct_pkg::A_SON, 8'h30};
  logic [31:0] rst_v [6] = '{32'h0, 32'h1, 32'h1, 32'h4, 32'h3e8, 32'h0};
  mgct_top #(.BTN_SHORT_CYC(20), .BTN_LONG_CYC(60)) u_mgct_top (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .cnt_in(cnt_p),
    .start_in(start_p), .stop_in(stop_p), .gate_in(gate_p), .reset_btn_n(reset_btn_n),
    .run_out(run_out), .gate_led(gate_led), .sys_rst_req(sys_rst_req), .fw_update(fw_update),
    .disp_top(disp_top), .disp_bot(disp_bot));
  mgct_pins u_mgct_pins (.hclk(hclk), .cnt_out(cnt_p), .start_out(start_p), .stop_out(stop_p),
    .gate_out(gate_p));
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  // Wait for hready high at a falling edge; data taken at that edge
  task automatic rdy(output logic [31:0] d);
    int n;
    n = 0;
    @(negedge hclk);
    while (hreadyout !== 1'b1 && n < 50) begin
      @(negedge hclk);
      n++;
    end
    d = hrdata;
    if (n >= 50) begin
      failures++;
      conclude();
    end
    @(posedge hclk);
  endtask : rdy
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'($random(seed)), a};
    rdy(r);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy(r);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    bus(1'b0, a, $random(seed), r);
  endtask : rd
  // Bounded wait for run_out or the reset request to reach a level
  task automatic await(input logic w, input logic v, input int lim);
    int n;
    n = 0;
    check_count++;
    while ((w ? sys_rst_req : run_out) !== v && n < lim) begin
      @(negedge hclk);
      n++;
    end
    if (n >= lim) begin
      failures++;
      conclude();
    end
    @(posedge hclk);
  endtask : await
  function automatic logic [31:0] disp_exp(input int s);
    case (s)
      0: return 32'h0;
      1: return 32'h3;
      2: return 32'h5;
      default: return 32'h7;
    endcase
  endfunction : disp_exp
  initial begin
    int i;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = '0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = '0;
    reset_btn_n = 1'b1;
    seed = 32'h1671;
    failures = 0;
    check_count = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(negedge hclk);
    `CHK(run_out, 1'b0)
    `CHK(disp_bot, 32'h0)
    @(posedge hclk);
    for (i = 0; i < 6; i++) begin
      rd(rst_a[i], q);
      `CHK(q, rst_v[i])
    end
    wr(mgct_pkg::A_CTRL, 32'h800);
    repeat (4) @(posedge hclk);
    `CHK(run_out, 1'b1)
    wr(mgct_pkg::A_CTRL, 32'h0);
    repeat (4) @(posedge hclk);
    `CHK(run_out, 1'b0)
    // Free run with random pulse counts, gated and stopped spans
    u_mgct_pins.kick(1'b0);
    await(1'b0, 1'b1, 20);
    `CHK(gate_led, 1'b1)
    rd(mgct_pkg::A_STAT, q);
    `CHK(q[2:0], 3'b010)
    for (i = 0; i < 8; i++) begin
      nexp[i] = ($random(seed) & 7) + 1;
      u_mgct_pins.burst(8'(1 << i), nexp[i]);
    end
    u_mgct_pins.gate(1'b0);
    `CHK(gate_led, 1'b0)
    u_mgct_pins.burst(8'($random(seed)), 3);
    u_mgct_pins.gate(1'b1);
    u_mgct_pins.kick(1'b1);
    await(1'b0, 1'b0, 20);
    u_mgct_pins.burst(8'($random(seed)), 2);
    for (i = 0; i < 8; i++) begin
      rd(mgct_pkg::A_CNT + 8'(4 * i), q);
      `CHK(q, 32'(nexp[i]))
    end
    `CHK(hresp, 1'b0)
    // Snapshots on gate changes: ch1 word, then second entry
    wr(mgct_pkg::A_CTRL, 32'h2004);
    u_mgct_pins.kick(1'b0);
    await(1'b0, 1'b1, 20);
    u_mgct_pins.burst(8'h02, 2);
    u_mgct_pins.gate(1'b0);
    u_mgct_pins.gate(1'b1);
    u_mgct_pins.kick(1'b1);
    rd(mgct_pkg::A_SCNT, q);
    `CHK(q, 32'h2)
    wr(mgct_pkg::A_SIDX, 32'h1);
    rd(mgct_pkg::A_SDATA, q);
    `CHK(q, 32'h2)
    wr(mgct_pkg::A_SIDX, 32'ha);
    rd(mgct_pkg::A_SDATA, q);
    `CHK(q, 32'h2)
    // Channel 7 limit stop, other channels cannot end the run
    wr(mgct_pkg::A_PCNT, 32'h5);
    wr(mgct_pkg::A_CTRL, 32'h24);
    u_mgct_pins.kick(1'b0);
    await(1'b0, 1'b1, 20);
    u_mgct_pins.burst(8'h01, 8);
    `CHK(run_out, 1'b1)
    u_mgct_pins.burst(8'h80, 8);
    await(1'b0, 1'b0, 20);
    rd(mgct_pkg::A_CNT + 8'h1c, q);
    `CHK(q, 32'h5)
    rd(mgct_pkg::A_CNT, q);
    `CHK(q, 32'h8)
    u_mgct_pins.kick(1'b0);
    repeat (4) @(posedge hclk);
    `CHK(run_out, 1'b0)
    // Timer stop after 3 us
    wr(mgct_pkg::A_PTMR_LO, 32'h3);
    wr(mgct_pkg::A_CTRL, 32'h14);
    u_mgct_pins.kick(1'b0);
    await(1'b0, 1'b1, 20);
    await(1'b0, 1'b0, 1000);
    rd(mgct_pkg::A_TMR, q);
    `CHK(q, 32'h3)
    wr(mgct_pkg::A_PTMR_LO, 32'h7);
    for (i = 0; i < 4; i++) begin
      wr(mgct_pkg::A_DISP, 32'(i | ((3 - i) << 2)));
      repeat (3) @(posedge hclk);
      `CHK(disp_top, disp_exp(i))
      `CHK(disp_bot, disp_exp(3 - i))
    end
    // Internal clock snapshots: first phase change stores one entry
    wr(mgct_pkg::A_SON, 32'h1);
    wr(mgct_pkg::A_CTRL, 32'h3004);
    u_mgct_pins.kick(1'b0);
    i = 0;
    q = 32'h8;
    while (q[mgct_pkg::B_GATE] && i < 100) begin
      rd(mgct_pkg::A_STAT, q);
      i++;
    end
    `CHK(q[mgct_pkg::B_GATE], 1'b0)
    u_mgct_pins.kick(1'b1);
    rd(mgct_pkg::A_SCNT, q);
    `CHK(q, 32'h1)
    // Short press, then long press of the button
    reset_btn_n <= 1'b0;
    repeat (10) @(posedge hclk);
    reset_btn_n <= 1'b1;
    await(1'b1, 1'b1, 30);
    `CHK(fw_update, 1'b0)
    reset_btn_n <= 1'b0;
    repeat (80) @(posedge hclk);
    reset_btn_n <= 1'b1;
    repeat (6) @(posedge hclk);
    `CHK(fw_update, 1'b1)
    conclude();
  end
endmodule : mgct_top_tb
